// >>> hdl/dac_cal_store.sv
// dac_cal_store: flip-flop store of signed offset and gain correction words.
// assumes the index is composed by software: channel, range, kind.
`timescale 1ns/1ns
`default_nettype none
module dac_cal_store
  import dac_irq_pkg::*;
#(
  parameter int DEPTH = CAL_DEPTH,
  parameter int AW = CAL_ADDR_W
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [WORD_W-1:0] wdata,
  output logic [WORD_W-1:0] rd_word
);
  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] mem;
  } cal_s;
  localparam cal_s CAL_RESET = '0;
  cal_s st;
  cal_s next_st;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // full 16-bit signed span, no clamping: every code is a legal correction
  always_comb
  begin
    next_st = st;
    if (wr_en)
      next_st.mem[addr] = wdata;
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st <= CAL_RESET;
    else
      st <= next_st;
  end
  assign rd_word = st.mem[addr];
endmodule // dac_cal_store
`default_nettype wire

// >>> hdl/dac_code_map.sv
// dac_code_map: turns a host dac word into the straight-binary level that
// drives the converter. assumes the range select is stable with the word.
`timescale 1ns/1ns
`default_nettype none
module dac_code_map
  import dac_irq_pkg::*;
(
  input wire logic [WORD_W-1:0] word,
  input wire logic bipolar,
  output logic [WORD_W-1:0] level
);
  // ----------------------------------------------------------------
  // two's complement vs straight binary
  // ----------------------------------------------------------------
  // flipping the sign bit maps 0x8000 to the bottom and 0x7FFF to the top
  always_comb
  begin
    if (bipolar)
      level = word ^ SIGN_FLIP;
    else
      level = word;
  end
endmodule // dac_code_map
`default_nettype wire

// >>> hdl/dac_irq_coding.sv
// dac_irq_coding: interrupt sources, output coding and correction store
// for a multi-group 16-bit dac board.
// assumes event inputs are one-cycle pulses synchronous to clk_sys and
// fifo level flags come from the fifo logic already compared to limits.
//
// Operation
// - bipolar ranges read the word as two's complement, 0x7FFF top, 0x8000 bottom.
// - unipolar ranges read the word as straight binary, 0xFFFF top, 0x0000 zero.
// - one fifo flag combines all fifos enabled in the fifo enable register.
// - fifo flag sets when an enabled fifo is below limit or empty.
// - fifo flag clears by itself once all enabled fifos are refilled.
// - per-fifo status view shows which fifo raised the fifo flag.
// - per-group sequencer bit sets on a data-set request when enabled.
// - per-group load bit sets on an output update in memory mode when enabled.
// - per-group alert bit sets when a status read shows overcurrent or thermal.
// - offset and gain corrections are 16-bit signed, quarter-step scaled.
// - corrections kept for every channel and every range setting.
// - in fifo and timer modes one group status read per sequence.
`timescale 1ns/1ns
`default_nettype none
module dac_irq_coding
  import dac_irq_pkg::*;
#(
  parameter int NUM_GROUPS = DEF_NUM_GROUPS,
  parameter int CH_PER_GROUP = DEF_CH_PER_GROUP,
  parameter int NUM_FIFOS = DEF_NUM_FIFOS,
  parameter int OC_PER_GROUP = DEF_OC_PER_GROUP
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DATA_W-1:0] bus_rdata,
  input wire logic [NUM_FIFOS-1:0] fifo_below_limit,
  input wire logic [NUM_FIFOS-1:0] fifo_empty,
  input wire logic [2*NUM_GROUPS-1:0] group_mode,
  input wire logic [NUM_GROUPS-1:0] seq_request,
  input wire logic [NUM_GROUPS-1:0] seq_done,
  input wire logic [NUM_GROUPS-1:0] load_done,
  input wire logic [NUM_GROUPS-1:0] status_read_done,
  input wire logic [OC_PER_GROUP*NUM_GROUPS-1:0] status_overcurrent,
  input wire logic [NUM_GROUPS-1:0] status_thermal,
  output logic [NUM_GROUPS-1:0] status_read_req,
  input wire logic [WORD_W-1:0] dac_word,
  input wire logic [$clog2(NUM_GROUPS*CH_PER_GROUP)-1:0] dac_chan,
  input wire logic dac_word_valid,
  output logic [WORD_W-1:0] dac_level,
  output logic dac_level_valid,
  output logic fifo_low_irq,
  output logic irq
);
  localparam int GRP_FIELDS = 3 * NUM_GROUPS;
  localparam int SEQ_BASE = 0;
  localparam int LOAD_BASE = NUM_GROUPS;
  localparam int ALERT_BASE = 2 * NUM_GROUPS;
  localparam int GRP_W = $clog2(NUM_GROUPS);
  localparam int CH_W = $clog2(NUM_GROUPS * CH_PER_GROUP);
  localparam int GRP_SHIFT = $clog2(CH_PER_GROUP);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [GRP_FIELDS-1:0] grp_status;
    logic [GRP_FIELDS-1:0] grp_enable;
    logic [NUM_FIFOS-1:0] fifo_enable;
    logic [NUM_FIFOS-1:0] fifo_status;
    logic [RANGE_W*NUM_GROUPS-1:0] range;
    logic [CAL_ADDR_W-1:0] cal_addr;
    logic [WORD_W-1:0] level;
    logic level_valid;
    logic [NUM_GROUPS-1:0] stat_req;
  } state_s;
  localparam state_s STATE_RESET = '0;

  state_s st;
  state_s next_st;
  logic [GRP_FIELDS-1:0] grp_set;
  logic [NUM_GROUPS-1:0] seq_ft_mode;
  logic [WORD_W-1:0] mapped_level;
  logic [WORD_W-1:0] cal_rd_word;
  logic [RANGE_W-1:0] chan_range;
  logic wr_grp_status;
  logic wr_cal_data;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [RANGE_W-1:0] range_of(
    input logic [RANGE_W*NUM_GROUPS-1:0] r,
    input logic [GRP_W-1:0] g);
    range_of = r[g*RANGE_W +: RANGE_W];
  endfunction

  function automatic logic any_field(
    input logic [GRP_FIELDS-1:0] v,
    input int base);
    any_field = |v[base +: NUM_GROUPS];
  endfunction

  // ----------------------------------------------------------------
  // per-group event qualification
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_grp
    assign grp_set[SEQ_BASE+g] = seq_request[g] & st.grp_enable[SEQ_BASE+g];
    assign grp_set[LOAD_BASE+g] = load_done[g] & st.grp_enable[LOAD_BASE+g]
      & (group_mode[2*g +: 2] == MODE_M);
    assign grp_set[ALERT_BASE+g] = status_read_done[g] & st.grp_enable[ALERT_BASE+g]
      & ((|status_overcurrent[OC_PER_GROUP*g +: OC_PER_GROUP]) | status_thermal[g]);
    assign seq_ft_mode[g] = (group_mode[2*g +: 2] == MODE_F) | (group_mode[2*g +: 2] == MODE_T);
  end

  assign chan_range = range_of(st.range, dac_chan[CH_W-1:GRP_SHIFT]);
  assign wr_grp_status = bus_wr && (bus_addr == OFS_GRP_STATUS);
  assign wr_cal_data = bus_wr && (bus_addr == OFS_CAL_DATA);

  dac_code_map u_code_map (
    .word(dac_word),
    .bipolar(chan_range[RANGE_BIPOLAR_BIT]),
    .level(mapped_level)
  );

  dac_cal_store #(
    .DEPTH(CAL_DEPTH),
    .AW(CAL_ADDR_W)
  ) u_cal_store (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wr_en(wr_cal_data),
    .addr(st.cal_addr),
    .wdata(bus_wdata[WORD_W-1:0]),
    .rd_word(cal_rd_word)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // level-sensitive: follows the fifo flags, no acknowledge needed
    next_st.fifo_status = st.fifo_enable & (fifo_below_limit | fifo_empty);
    // set wins over a same-cycle write-one-to-clear
    if (wr_grp_status)
      next_st.grp_status = (st.grp_status & ~bus_wdata[GRP_FIELDS-1:0]) | grp_set;
    else
      next_st.grp_status = st.grp_status | grp_set;
    next_st.stat_req = seq_done & seq_ft_mode;
    next_st.level_valid = dac_word_valid;
    if (dac_word_valid)
      next_st.level = mapped_level;
    // the group enable doubles as the mask: dropping it keeps status, silences irq
    if (bus_wr)
    begin
      if (bus_addr == OFS_GRP_ENABLE)
        next_st.grp_enable = bus_wdata[GRP_FIELDS-1:0];
      else if (bus_addr == OFS_FIFO_ENABLE)
        next_st.fifo_enable = bus_wdata[NUM_FIFOS-1:0];
      else if (bus_addr == OFS_RANGE)
        next_st.range = bus_wdata[RANGE_W*NUM_GROUPS-1:0];
      else if (bus_addr == OFS_CAL_ADDR)
        next_st.cal_addr = bus_wdata[CAL_ADDR_W-1:0];
    end
    // idle cycles read zero so a late sample cannot pass for fresh data
    next_st.rdata = '0;
    if (bus_rd)
    begin
      if (bus_addr == OFS_IRQ_SUMMARY)
        next_st.rdata = DATA_W'({irq, any_field(st.grp_status, ALERT_BASE),
          any_field(st.grp_status, LOAD_BASE), any_field(st.grp_status, SEQ_BASE), fifo_low_irq});
      else if (bus_addr == OFS_GRP_STATUS)
        next_st.rdata = DATA_W'(st.grp_status);
      else if (bus_addr == OFS_GRP_ENABLE)
        next_st.rdata = DATA_W'(st.grp_enable);
      else if (bus_addr == OFS_FIFO_ENABLE)
        next_st.rdata = DATA_W'(st.fifo_enable);
      else if (bus_addr == OFS_FIFO_STATUS)
        next_st.rdata = DATA_W'(st.fifo_status);
      else if (bus_addr == OFS_RANGE)
        next_st.rdata = DATA_W'(st.range);
      else if (bus_addr == OFS_CAL_ADDR)
        next_st.rdata = DATA_W'(st.cal_addr);
      else if (bus_addr == OFS_CAL_DATA)
        next_st.rdata = DATA_W'(cal_rd_word);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st <= STATE_RESET;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata = st.rdata;
  assign status_read_req = st.stat_req;
  assign dac_level = st.level;
  assign dac_level_valid = st.level_valid;
  assign fifo_low_irq = |st.fifo_status;
  assign irq = fifo_low_irq | (|(st.grp_status & st.grp_enable));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  fifo_flag_set_a: assert property ((|(st.fifo_enable & (fifo_below_limit | fifo_empty)))
    |=> fifo_low_irq) else $error("fifo flag not set");
  fifo_self_clear_a: assert property (!(|(st.fifo_enable & (fifo_below_limit | fifo_empty)))
    |=> !fifo_low_irq) else $error("fifo flag did not clear");
  fifo_view_a: assert property (bus_rd && (bus_addr == OFS_FIFO_STATUS)
    |=> bus_rdata == DATA_W'($past(st.fifo_status))) else $error("fifo view wrong");
  seq_set_a: assert property (seq_request[0] && st.grp_enable[SEQ_BASE]
    |=> st.grp_status[SEQ_BASE]) else $error("sequencer bit not set");
  load_set_a: assert property (load_done[0] && st.grp_enable[LOAD_BASE]
    && (group_mode[1:0] == MODE_M) |=> st.grp_status[LOAD_BASE]) else $error("load bit not set");
  alert_set_a: assert property (status_read_done[0] && st.grp_enable[ALERT_BASE]
    && status_thermal[0] |=> st.grp_status[ALERT_BASE]) else $error("alert bit not set");
  blocked_set_a: assert property (!st.grp_enable[SEQ_BASE] && !st.grp_status[SEQ_BASE]
    |=> !st.grp_status[SEQ_BASE]) else $error("disabled bit was set");
  sticky_bit_a: assert property (st.grp_status[SEQ_BASE] && !(wr_grp_status && bus_wdata[SEQ_BASE])
    |=> st.grp_status[SEQ_BASE]) else $error("sticky bit lost");
  irq_raise_a: assert property (seq_request[0] && st.grp_enable[SEQ_BASE]
    |-> ##[1:2] irq) else $error("interrupt not raised");
  irq_quiet_a: assert property ((st.grp_enable == '0) && (st.fifo_status == '0)
    |-> !irq) else $error("interrupt without a source");
  bip_code_a: assert property (dac_word_valid && chan_range[RANGE_BIPOLAR_BIT] && (dac_word == BIP_NEG_FS)
    |=> dac_level == UNI_ZERO) else $error("bipolar bottom code wrong");
  bip_top_a: assert property (dac_word_valid && chan_range[RANGE_BIPOLAR_BIT] && (dac_word == BIP_POS_FS)
    |=> dac_level == UNI_FS) else $error("bipolar top code wrong");
  bip_mid_a: assert property (dac_word_valid && chan_range[RANGE_BIPOLAR_BIT] && (dac_word == BIP_MID)
    |=> dac_level == UNI_MID) else $error("bipolar mid code wrong");
  uni_code_a: assert property (dac_word_valid && !chan_range[RANGE_BIPOLAR_BIT] && (dac_word == UNI_MID)
    |=> dac_level == UNI_MID) else $error("unipolar mid code wrong");
  uni_top_a: assert property (dac_word_valid && !chan_range[RANGE_BIPOLAR_BIT] && (dac_word == UNI_FS)
    |=> dac_level == UNI_FS) else $error("unipolar top code wrong");
  uni_zero_a: assert property (dac_word_valid && !chan_range[RANGE_BIPOLAR_BIT] && (dac_word == UNI_ZERO)
    |=> dac_level == UNI_ZERO) else $error("unipolar zero code wrong");
  level_valid_a: assert property (dac_word_valid |=> dac_level_valid) else $error("level strobe missing");
  stat_req_a: assert property (seq_done[0] && (group_mode[1:0] == MODE_T)
    |=> status_read_req[0]) else $error("status read not requested");
  cal_rw_a: assert property (wr_cal_data ##1 (bus_rd && (bus_addr == OFS_CAL_DATA))
    |=> bus_rdata[WORD_W-1:0] == $past(bus_wdata[WORD_W-1:0], 2)) else $error("correction word lost");

  // ----------------------------------------------------------------
  // per-group lanes
  // ----------------------------------------------------------------
  // lane 0 is checked in detail above; a miswired index shows up here
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_chk
    lane_seq_a: assert property (seq_request[g] && st.grp_enable[SEQ_BASE+g]
      |=> st.grp_status[SEQ_BASE+g]) else $error("lane sequencer bit not set");
    lane_load_a: assert property (load_done[g] && st.grp_enable[LOAD_BASE+g]
      && (group_mode[2*g +: 2] == MODE_M) |=> st.grp_status[LOAD_BASE+g]) else $error("lane load bit not set");
    lane_alert_a: assert property (status_read_done[g] && st.grp_enable[ALERT_BASE+g]
      && (|status_overcurrent[OC_PER_GROUP*g +: OC_PER_GROUP])
      |=> st.grp_status[ALERT_BASE+g]) else $error("lane alert bit not set");
    lane_gate_a: assert property (!st.grp_enable[LOAD_BASE+g] && !st.grp_status[LOAD_BASE+g]
      |=> !st.grp_status[LOAD_BASE+g]) else $error("disabled load bit was set");
    lane_mode_a: assert property (load_done[g] && (group_mode[2*g +: 2] != MODE_M)
      && !st.grp_status[LOAD_BASE+g] |=> !st.grp_status[LOAD_BASE+g]) else $error("load outside memory mode");
    load_hold_a: assert property (st.grp_status[LOAD_BASE+g] && !(wr_grp_status && bus_wdata[LOAD_BASE+g])
      |=> st.grp_status[LOAD_BASE+g]) else $error("load bit lost");
    alert_hold_a: assert property (st.grp_status[ALERT_BASE+g] && !(wr_grp_status && bus_wdata[ALERT_BASE+g])
      |=> st.grp_status[ALERT_BASE+g]) else $error("alert bit lost");
    lane_req_a: assert property (seq_done[g] && (group_mode[2*g +: 2] == MODE_F)
      |=> status_read_req[g]) else $error("lane status read not requested");
    lane_idle_a: assert property (seq_done[g] && (group_mode[2*g +: 2] == MODE_I)
      |=> !status_read_req[g]) else $error("status read requested in direct mode");
  end

  // per-fifo view must match the combined flag lane by lane
  for (genvar f = 0; f < NUM_FIFOS; f++)
  begin : g_fifo_chk
    fifo_lane_a: assert property (st.fifo_enable[f] && (fifo_below_limit[f] || fifo_empty[f])
      |=> st.fifo_status[f]) else $error("fifo lane not flagged");
    fifo_drop_a: assert property (!fifo_below_limit[f] && !fifo_empty[f]
      |=> !st.fifo_status[f]) else $error("fifo lane did not clear");
    fifo_mask_a: assert property (!st.fifo_enable[f] |=> !st.fifo_status[f]) else $error("disabled fifo flagged");
  end

  fifo_irq_c: cover property (!fifo_low_irq ##1 fifo_low_irq ##[1:20] !fifo_low_irq);
  load_c: cover property (grp_set[LOAD_BASE] ##1 irq);
  seq_ack_c: cover property (st.grp_status[SEQ_BASE] ##1 !st.grp_status[SEQ_BASE]);
  alert_c: cover property (grp_set[ALERT_BASE] ##1 irq);
  set_clear_c: cover property (wr_grp_status && grp_set[SEQ_BASE] && bus_wdata[SEQ_BASE]);
endmodule // dac_irq_coding
`default_nettype wire

// >>> hdl/dac_irq_pkg.sv
// dac_irq_pkg: shared constants for the dac interrupt and coding block.
// assumes a 32-bit local register port with byte addresses.
package dac_irq_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DEF_NUM_GROUPS = 8;
  localparam int DEF_CH_PER_GROUP = 4;
  localparam int DEF_NUM_FIFOS = 32;
  localparam int DEF_OC_PER_GROUP = 4;
  localparam int WORD_W = 16;
  localparam int RANGE_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CAL_ADDR_W = 9;
  localparam int CAL_DEPTH = 512;
  localparam int CAL_MIN = -32768;
  localparam int CAL_MAX = 32767;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_IRQ_SUMMARY = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GRP_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GRP_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FIFO_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FIFO_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RANGE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CAL_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CAL_DATA = 8'h1C;
  // ----------------------------------------------------------------
  // coding
  // ----------------------------------------------------------------
  localparam int RANGE_BIPOLAR_BIT = 2;
  localparam logic [WORD_W-1:0] BIP_POS_FS = 16'h7FFF;
  localparam logic [WORD_W-1:0] BIP_MID = 16'h0000;
  localparam logic [WORD_W-1:0] BIP_NEG_FS = 16'h8000;
  localparam logic [WORD_W-1:0] UNI_FS = 16'hFFFF;
  localparam logic [WORD_W-1:0] UNI_MID = 16'h8000;
  localparam logic [WORD_W-1:0] UNI_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] SIGN_FLIP = 16'h8000;
  typedef enum logic [1:0] {
    MODE_I = 2'b00,
    MODE_M = 2'b01,
    MODE_F = 2'b10,
    MODE_T = 2'b11
  } group_mode_e;
endpackage

// >>> test/dac_irq_coding_tb.sv
// dac_irq_coding_tb: random and corner stimulus for the interrupt and coding block.
// assumes default sizes: 8 groups, 32 fifos.
`timescale 1ns/1ns
`default_nettype none
module dac_irq_coding_tb;
  import dac_irq_pkg::*;
  logic clk_sys, nrst, bus_wr, bus_rd, dac_word_valid, dac_level_valid, fifo_low_irq, irq;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata, d, en, bl, em;
  logic [31:0] fifo_below_limit, fifo_empty, status_overcurrent;
  logic [15:0] group_mode, dac_word, dac_level;
  logic [7:0] seq_request, seq_done, load_done, status_read_done, status_thermal, status_read_req, g;
  logic [4:0] dac_chan;
  logic [15:0] words [6];
  int mismatches, compares, seed, k;
  dac_irq_coding dut (.clk_sys(clk_sys), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fifo_below_limit(fifo_below_limit),
    .fifo_empty(fifo_empty), .group_mode(group_mode), .seq_request(seq_request), .seq_done(seq_done),
    .load_done(load_done), .status_read_done(status_read_done), .status_overcurrent(status_overcurrent),
    .status_thermal(status_thermal), .status_read_req(status_read_req), .dac_word(dac_word),
    .dac_chan(dac_chan), .dac_word_valid(dac_word_valid), .dac_level(dac_level),
    .dac_level_valid(dac_level_valid), .fifo_low_irq(fifo_low_irq), .irq(irq));
  host_bus_model host (.clk_sys(clk_sys), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_level(input logic [15:0] w, input logic bip);
    return bip ? {~w[15], w[14:0]} : w;
  endfunction
  // all three group events at once; flags are garbage outside the read pulse
  task automatic ev(input logic [7:0] m, input int n, input logic oc);
    @(posedge clk_sys);
    seq_request <= m;
    load_done <= m;
    status_read_done <= m;
    status_thermal <= oc ? 8'h00 : m;
    status_overcurrent <= oc ? (32'h1 << (4 * n + (n % 4))) : 32'h0;
    @(posedge clk_sys);
    seq_request <= '0;
    load_done <= '0;
    status_read_done <= '0;
    status_thermal <= 8'hFF;
    status_overcurrent <= '1;
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {nrst, fifo_below_limit, fifo_empty, group_mode, seq_request, seq_done, load_done} = '0;
    {status_read_done, status_overcurrent, status_thermal, dac_word, dac_chan, dac_word_valid} = '0;
    seed = 83;
    words = '{16'h7FFF, 16'h0000, 16'h8000, 16'hFFFF, 16'h0001, 16'h8001};
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    host.rd(OFS_IRQ_SUMMARY, d);
    check(d, 32'h0);
    host.rd(8'hF0, d);
    check(d, 32'h0);
    for (int b = 0; b < 2; b++)
    begin
      host.wr(OFS_RANGE, b ? 32'h00924924 : 32'h0);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge clk_sys);
        dac_word <= (i < 6) ? words[i] : 16'($random(seed));
        dac_chan <= 5'($random(seed));
        dac_word_valid <= 1'b1;
        @(posedge clk_sys);
        dac_word_valid <= 1'b0;
        #1;
        check({dac_level_valid, dac_level}, {1'b1, exp_level(dac_word, b[0])});
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      k = $unsigned($random(seed)) % 8;
      g = 8'h1 << k;
      @(posedge clk_sys);
      group_mode <= 16'h0;
      host.wr(OFS_GRP_ENABLE, 32'h0);
      ev(g, k, i[0]);
      host.rd(OFS_GRP_STATUS, d);
      check(d, 32'h0);
      host.wr(OFS_GRP_ENABLE, 32'h00FFFFFF);
      ev(g, k, i[0]);
      host.rd(OFS_GRP_STATUS, d);
      check(d, {8'h0, g, 8'h0, g});
      @(posedge clk_sys);
      group_mode <= 16'h5555;
      ev(g, k, ~i[0]);
      host.rd(OFS_GRP_STATUS, d);
      check(d, {8'h0, g, g, g});
      check(irq, 1'b1);
      host.rd(OFS_IRQ_SUMMARY, d);
      check(d, 32'h1E);
      host.wr(OFS_GRP_ENABLE, 32'h0);
      #1;
      check(irq, 1'b0);
      // next data set goes in before the request is acknowledged
      @(posedge clk_sys);
      dac_word <= 16'($random(seed));
      dac_word_valid <= 1'b1;
      @(posedge clk_sys);
      dac_word_valid <= 1'b0;
      #1;
      check({dac_level_valid, dac_level}, {1'b1, exp_level(dac_word, 1'b1)});
      host.ack({8'h0, g, g, g});
      host.rd(OFS_GRP_STATUS, d);
      check(d, 32'h0);
    end
    for (int m = 0; m < 4; m++)
    begin
      g = 8'($random(seed));
      @(posedge clk_sys);
      group_mode <= {8{m[1:0]}};
      seq_done <= g;
      @(posedge clk_sys);
      seq_done <= '0;
      #1;
      check(status_read_req, m[1] ? g : 8'h0);
    end
    for (int i = 0; i < 5; i++)
    begin
      en = $random(seed);
      bl = $random(seed);
      em = (i == 0) ? 32'h0 : $random(seed);
      host.wr(OFS_FIFO_ENABLE, en);
      fifo_below_limit <= bl;
      fifo_empty <= em;
      host.rd(OFS_FIFO_STATUS, d);
      check(d, en & (bl | em));
      check({irq, fifo_low_irq}, {2{|(en & (bl | em))}});
      @(posedge clk_sys);
      fifo_below_limit <= ~en;
      fifo_empty <= ~en;
      repeat (2) @(posedge clk_sys);
      check(fifo_low_irq, 1'b0);
    end
    for (int i = 0; i < 4; i++)
    begin
      en = (i == 0) ? 32'h0 : (i == 1) ? 32'h1FE : 32'($unsigned($random(seed)) % 256 * 2);
      bl = (i == 1) ? 32'h8000 : (i == 2) ? 32'h7FFF : 32'($random(seed) & 32'hFFFF);
      host.wr(OFS_CAL_ADDR, en);
      host.wr_rd(OFS_CAL_DATA, bl, d);
      check(d, bl);
      host.wr(OFS_CAL_ADDR, en | 32'h1);
      host.wr(OFS_CAL_DATA, ~bl & 32'hFFFF);
      host.wr(OFS_CAL_ADDR, en);
      host.rd(OFS_CAL_DATA, d);
      check(d, bl);
      host.wr(OFS_CAL_ADDR, en | 32'h1);
      host.rd(OFS_CAL_DATA, d);
      check(d, ~bl & 32'hFFFF);
    end
    end_of_test();
  end
endmodule // dac_irq_coding_tb
`default_nettype wire

// >>> test/host_bus_model.sv
// host_bus_model: host software side of the local register port.
// assumes the slave answers a read in the cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import dac_irq_pkg::*;
(
  input wire logic clk_sys,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [DATA_W-1:0] bus_rdata
);
  initial
  begin
    bus_addr = '0;
    bus_wdata = '0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    // stale data would hide a late capture
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    bus_wdata <= ~w;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  task automatic ack(input logic [DATA_W-1:0] bits);
    wr(OFS_GRP_STATUS, bits);
  endtask
endmodule // host_bus_model
`default_nettype wire
